// *** logic/fcm_cfg.svh ***
// Constants for the flash command and mode controller.
// Assumes a 50 MHz system clock and 32-bit CPU data path.
`ifndef FCM_CFG_SVH
`define FCM_CFG_SVH
`define FCM_CLK_MHZ 50
`define FCM_PROG_TIME_NS 2000
`define FCM_ERASE_TIME_NS 40000
`define FCM_PROT_TIME_NS 3000
`define FCM_EALL_TIME_NS 100000
`define FCM_BE_TMO_NS 50000
`define FCM_ADDR_W 19
`define FCM_NBLK 19
`define FCM_UNLOCK1_ADDR 19'h05554
`define FCM_UNLOCK2_ADDR 19'h0AAA8
`define FCM_D_UNLOCK1 8'hAA
`define FCM_D_UNLOCK2 8'h55
`define FCM_D_RESET 8'hF0
`define FCM_D_PROG 8'hA0
`define FCM_D_ERASE 8'h80
`define FCM_D_CHIP 8'h10
`define FCM_D_BLOCK 8'h30
`define FCM_ERASED 32'hFFFFFFFF
`define FCM_BLK32_LAST 5'h0E
`define FCM_BLK16_BASE 19'h78000
`define FCM_BLK8_BASE 19'h7C000
`define FCM_BLK4A_BASE 19'h7E000
`define FCM_BLK4B_BASE 19'h7F000
`define FCM_STAT_POLL 3
`define FCM_STAT_TOGGLE 2
`define FCM_STAT_FAIL 1
`define FCM_STAT_TMO 0
`endif

// *** logic/fcm_pkg.sv ***
// Types shared by the flash command and mode controller.
// Assumes fcm_cfg.svh is available on the include path.
`include "fcm_cfg.svh"
package fcm_pkg;
    typedef enum logic [1:0] {fcm_read, fcm_embedded, fcm_locked} fcm_mode_t;
    typedef struct packed
    {
        logic wr;
        logic rd;
        logic [`FCM_ADDR_W-1:0] addr;
        logic [31:0] data;
    } fcm_cpu_req_t;
    typedef struct packed
    {
        logic we;
        logic [`FCM_ADDR_W-1:0] addr;
        logic [31:0] data;
    } fcm_arr_wr_t;
endpackage : fcm_pkg

// *** logic/fcm_block_decode.sv ***
// Maps an array byte address onto one of nineteen erase blocks.
// Assumes the address is already within the array window.
`timescale 1ns/1ns
`default_nettype none
`include "fcm_cfg.svh"
module fcm_block_decode
    import fcm_pkg::*;
(
    input wire logic [`FCM_ADDR_W-1:0] i_addr,
    output logic [4:0] o_block
);
    // Fifteen 32K blocks, then 16K, 8K and two 4K blocks
    always_comb
    begin
        if (i_addr < `FCM_BLK16_BASE)
            o_block = {1'b0, i_addr[18:15]};
        else if (i_addr < `FCM_BLK8_BASE)
            o_block = 5'h0F;
        else if (i_addr < `FCM_BLK4A_BASE)
            o_block = 5'h10;
        else if (i_addr < `FCM_BLK4B_BASE)
            o_block = 5'h11;
        else
            o_block = 5'h12;
    end
endmodule : fcm_block_decode
`default_nettype wire

// *** logic/fcm_ctrl.sv ***
// Command front end and mode control for the on-chip flash array.
// Assumes a single-cycle array read port and an array that reports failures.
`timescale 1ns/1ns
`default_nettype none
`include "fcm_cfg.svh"
module fcm_ctrl
    import fcm_pkg::*;
#(
    parameter int PROG_CYC = (`FCM_PROG_TIME_NS * `FCM_CLK_MHZ) / 1000,
    parameter int ERASE_CYC = (`FCM_ERASE_TIME_NS * `FCM_CLK_MHZ) / 1000,
    parameter int PROT_CYC = (`FCM_PROT_TIME_NS * `FCM_CLK_MHZ) / 1000,
    parameter int EALL_CYC = (`FCM_EALL_TIME_NS * `FCM_CLK_MHZ) / 1000,
    parameter int TMO_CYC = (`FCM_BE_TMO_NS * `FCM_CLK_MHZ) / 1000
)
(
    input wire logic i_clock,
    input wire logic i_rst,
    input wire fcm_cpu_req_t i_cpu,
    input wire logic [31:0] i_array_rdata,
    input wire logic i_array_fail,
    input wire logic [`FCM_NBLK-1:0] i_protect,
    input wire logic i_security_off,
    output logic [31:0] o_rdata,
    output logic o_rvalid,
    output fcm_arr_wr_t o_array_wr,
    output logic o_busy,
    output logic o_read_mode,
    output logic [3:0] o_status
);
    typedef enum logic [2:0] {st_idle, st_c1, st_c2, st_c3, st_c4, st_c5, st_tmo, st_run} fcm_seq_t;

    // Low command byte of a cycle
    function automatic logic [7:0] cmd_byte(input logic [31:0] d);
        cmd_byte = d[7:0];
    endfunction : cmd_byte

    // Cycle count of at least one, truncated to the counter width
    function automatic logic [22:0] cyc(input int n);
        cyc = (n < 1) ? 23'h000001 : n[22:0];
    endfunction : cyc

    fcm_mode_t mode, next_mode;
    fcm_seq_t seq, next_seq;
    logic [22:0] cnt, next_cnt;
    logic [`FCM_NBLK-1:0] sel, next_sel;
    logic erase_op, next_erase_op;
    logic fail, next_fail;
    logic toggle, next_toggle;
    logic [31:0] rdata, next_rdata;
    logic rvalid, next_rvalid;
    fcm_arr_wr_t awr, next_awr;
    logic [4:0] blk;
    logic [7:0] cb;
    logic is_reset_cmd;
    logic [`FCM_NBLK-1:0] eff_sel;

    fcm_block_decode u_decode
    (
        .i_addr(i_cpu.addr),
        .o_block(blk)
    );

    assign cb = cmd_byte(i_cpu.data);
    assign is_reset_cmd = i_cpu.wr && (cb == `FCM_D_RESET);
    // Protected blocks drop out unless security off forces all
    assign eff_sel = i_security_off ? {`FCM_NBLK{1'b1}} : (sel & ~i_protect);

    // Sequence decoder, embedded timer and mode in one group
    always_comb
    begin
        next_mode = mode;
        next_seq = seq;
        next_cnt = cnt;
        next_sel = sel;
        next_erase_op = erase_op;
        next_fail = fail;
        next_toggle = toggle;
        next_rdata = 32'h00000000;
        next_rvalid = 1'b0;
        next_awr = '0;
        if (i_cpu.rd)
        begin
            next_rvalid = 1'b1;
            if (mode == fcm_read)
                next_rdata = i_array_rdata;
            else
            begin
                // Status word in place of array data
                // Poll bit stays low while locked as well, so a failed run never reads as finished
                next_rdata = {28'h0000000, mode == fcm_read, toggle, fail, seq == st_tmo};
                next_toggle = ~toggle;
            end
        end
        unique case (seq)
            st_idle:
                if (i_cpu.wr && mode == fcm_locked)
                begin
                    if (is_reset_cmd)
                    begin
                        next_mode = fcm_read;
                        next_fail = 1'b0;
                    end
                end
                else if (i_cpu.wr && cb == `FCM_D_UNLOCK1 && i_cpu.addr == `FCM_UNLOCK1_ADDR)
                    next_seq = st_c1;
            st_c1:
                if (i_cpu.wr)
                    next_seq = (cb == `FCM_D_UNLOCK2 && i_cpu.addr == `FCM_UNLOCK2_ADDR) ? st_c2 : st_idle;
            st_c2:
                if (i_cpu.wr)
                begin
                    next_seq = st_idle;
                    if (cb == `FCM_D_PROG)
                        next_seq = st_c3;
                    else if (cb == `FCM_D_ERASE)
                        next_seq = st_c4;
                end
            st_c3:
                if (i_cpu.wr)
                begin
                    next_seq = st_idle;
                    // Fourth cycle carries the full word
                    if (!is_reset_cmd && i_cpu.addr[1:0] == 2'b00)
                    begin
                        next_sel = '0;
                        next_sel[blk] = 1'b1;
                        next_erase_op = 1'b0;
                        if (i_protect[blk] && !i_security_off)
                            next_cnt = cyc(PROT_CYC);
                        else
                        begin
                            next_cnt = cyc(PROG_CYC);
                            next_awr = '{we: 1'b1, addr: i_cpu.addr, data: i_cpu.data};
                        end
                        next_seq = st_run;
                        next_mode = fcm_embedded;
                    end
                end
            st_c4:
                if (i_cpu.wr)
                    next_seq = (cb == `FCM_D_UNLOCK1) ? st_c5 : st_idle;
            st_c5:
                if (i_cpu.wr)
                begin
                    next_seq = st_idle;
                    next_erase_op = 1'b1;
                    next_mode = fcm_embedded;
                    if (cb == `FCM_D_CHIP)
                    begin
                        next_sel = {`FCM_NBLK{1'b1}};
                        next_cnt = cyc(EALL_CYC);
                        next_seq = st_run;
                    end
                    else if (cb == `FCM_D_BLOCK)
                    begin
                        next_sel = '0;
                        next_sel[blk] = 1'b1;
                        next_cnt = cyc(TMO_CYC);
                        next_seq = st_tmo;
                    end
                    else
                        next_mode = fcm_read;
                end
            st_tmo:
            begin
                // More blocks may join before the timeout runs out
                if (i_cpu.wr && cb == `FCM_D_BLOCK)
                begin
                    next_sel[blk] = 1'b1;
                    next_cnt = cyc(TMO_CYC);
                end
                else if (i_cpu.wr)
                begin
                    next_seq = st_idle;
                    next_mode = fcm_read;
                end
                else if (cnt == 23'h000001)
                begin
                    next_seq = st_run;
                    next_cnt = (eff_sel == '0) ? cyc(EALL_CYC) : cyc(ERASE_CYC);
                end
                else
                    next_cnt = cnt - 23'h000001;
            end
            st_run:
            begin
                // Timed internally, writes ignored meanwhile
                if (erase_op && i_array_fail)
                    next_fail = 1'b1;
                if (!erase_op && i_array_fail)
                    next_fail = 1'b1;
                if (cnt == 23'h000001)
                begin
                    next_seq = st_idle;
                    if (next_fail)
                        next_mode = fcm_locked;
                    else
                        next_mode = fcm_read;
                end
                else
                    next_cnt = cnt - 23'h000001;
                // Erased word goes out one cycle before the end so it lands while still busy;
                // a run of a single cycle therefore writes nothing
                if (erase_op && eff_sel != '0 && cnt == 23'h000002 && !next_fail)
                    next_awr = '{we: 1'b1, addr: '0, data: `FCM_ERASED};
            end
        endcase
    end

    // Synchronous chip reset forces read mode at once
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            mode <= fcm_read;
            seq <= st_idle;
            cnt <= 23'h000000;
            sel <= '0;
            erase_op <= 1'b0;
            fail <= 1'b0;
            toggle <= 1'b0;
            rdata <= 32'h00000000;
            rvalid <= 1'b0;
            awr <= '0;
        end
        else
        begin
            mode <= next_mode;
            seq <= next_seq;
            cnt <= next_cnt;
            sel <= next_sel;
            erase_op <= next_erase_op;
            fail <= next_fail;
            toggle <= next_toggle;
            rdata <= next_rdata;
            rvalid <= next_rvalid;
            awr <= next_awr;
        end
    end

    // Registered status outputs, all from flip-flops
    logic busy, next_busy;
    logic read_mode, next_read_mode;
    logic [3:0] stat, next_stat;
    always_comb
    begin
        next_busy = (next_mode != fcm_read);
        next_read_mode = (next_mode == fcm_read);
        next_stat = {next_mode == fcm_read, next_toggle, next_fail, next_seq == st_tmo};
    end
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            busy <= 1'b0;
            read_mode <= 1'b1;
            stat <= 4'h8;
        end
        else
        begin
            busy <= next_busy;
            read_mode <= next_read_mode;
            stat <= next_stat;
        end
    end

    assign o_rdata = rdata;
    assign o_rvalid = rvalid;
    assign o_array_wr = awr;
    assign o_busy = busy;
    assign o_read_mode = read_mode;
    assign o_status = stat;
endmodule : fcm_ctrl
`default_nettype wire

// *** verification/fcm_ctrl_monitor.sv ***
// Port checker for the flash command and mode controller.
// Assumes it is bound onto fcm_ctrl and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none
module fcm_ctrl_monitor
    import fcm_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst,
    input wire fcm_cpu_req_t i_cpu,
    input wire logic [31:0] i_array_rdata,
    input wire logic [31:0] o_rdata,
    input wire logic o_rvalid,
    input wire fcm_arr_wr_t o_array_wr,
    input wire logic o_busy,
    input wire logic o_read_mode,
    input wire logic [3:0] o_status
);
    // Single clock domain, so clock and reset are given once
    default clocking mon_cb @(posedge i_clock);
    endclocking
    default disable iff (i_rst);

    a_rvalid_follows_rd: assert property (i_cpu.rd |=> o_rvalid)
        else $error("read cycle got no answer");
    a_rvalid_has_cause: assert property (o_rvalid |-> $past(i_cpu.rd))
        else $error("answer without a read cycle");
    a_read_gives_word: assert property (i_cpu.rd && o_read_mode |=> o_rdata == $past(i_array_rdata))
        else $error("read mode did not return the array word");
    a_busy_hides_array: assert property (i_cpu.rd && o_busy |=> o_rdata[31:4] == 28'h0)
        else $error("array data leaked during an operation");
    a_mode_is_inverse: assert property (o_read_mode == !o_busy)
        else $error("read mode and busy disagree");
    // Reset itself is the cause here, so this one is never disabled
    a_reset_to_read: assert property (disable iff (1'b0) i_rst |=> o_read_mode && o_status == 4'h8 && !o_rvalid)
        else $error("reset did not force read mode");
    a_poll_tracks_mode: assert property (o_status[3] == o_read_mode)
        else $error("polling bit does not follow the mode");
    a_run_lasts: assert property ($rose(o_busy) |-> o_busy [*2])
        else $error("operation ended at once");
    a_array_write_runs: assert property (o_array_wr.we |-> o_busy)
        else $error("array written outside an operation");
endmodule : fcm_ctrl_monitor
`default_nettype wire

// *** verification/fcm_cpu_model.sv ***
// Stand-in for the on-chip CPU that issues command and read cycles.
// Assumes one-cycle strobes are sampled on the rising clock edge.
`timescale 1ns/1ns
`default_nettype none
module fcm_cpu_model
    import fcm_pkg::*;
(
    input wire logic i_clock,
    output var fcm_cpu_req_t o_cpu
);
    initial o_cpu = '0;

    // One bus cycle; after release address and data are inverted so stale values never pass for fresh ones
    task automatic cyc(input logic w, input logic [18:0] a, input logic [31:0] d);
        @(posedge i_clock);
        #1;
        o_cpu = '{wr: w, rd: !w, addr: a, data: d};
        @(posedge i_clock);
        #1;
        o_cpu = '{wr: 1'b0, rd: 1'b0, addr: ~a, data: ~d};
    endtask : cyc
endmodule : fcm_cpu_model
`default_nettype wire

// *** verification/fcm_ctrl_tb_top.sv ***
// Self-checking bench for the flash command and mode controller.
// Assumes the CPU model drives requests and a combinational array stand-in answers.
`timescale 1ns/1ns
`default_nettype none
`include "fcm_cfg.svh"
module fcm_ctrl_tb_top
    import fcm_pkg::*;
;
    logic i_clock;
    logic i_rst = 1'b1;
    logic fail = 1'b0;
    logic sec = 1'b0;
    logic [18:0] prot = 19'h0;
    fcm_cpu_req_t cpu;
    fcm_arr_wr_t awr;
    logic [31:0] rdata;
    logic rvalid;
    logic busy;
    logic rmode;
    logic [3:0] status;
    int num_errors = 0;
    int tests_run = 0;
    int n_wr = 0;

    initial
    begin
        i_clock = 1'b0;
        forever #10 i_clock = ~i_clock;
    end

    // Short run times keep the whole bench to a few hundred cycles
    fcm_ctrl #(.PROG_CYC(4), .ERASE_CYC(4), .PROT_CYC(4), .EALL_CYC(4), .TMO_CYC(4)) fcm_ctrl_inst (
        .i_clock(i_clock), .i_rst(i_rst), .i_cpu(cpu), .i_array_rdata({13'h1ABC, cpu.addr}),
        .i_array_fail(fail), .i_protect(prot), .i_security_off(sec), .o_rdata(rdata), .o_rvalid(rvalid),
        .o_array_wr(awr), .o_busy(busy), .o_read_mode(rmode), .o_status(status));
    fcm_cpu_model fcm_cpu_model_inst (.i_clock(i_clock), .o_cpu(cpu));

    task automatic give_verdict();
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : give_verdict

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            $display("MISMATCH %s expected %h seen %h", n, e, g);
            num_errors++;
        end
    endtask : chk

    task automatic wr(input logic [18:0] a, input logic [31:0] d);
        fcm_cpu_model_inst.cyc(1'b1, a, d);
    endtask : wr

    // Read data is taken at the edge after the strobe, where the answer stands
    task automatic rd(input logic [18:0] a);
        fcm_cpu_model_inst.cyc(1'b0, a, 32'h0);
    endtask : rd

    task automatic unlock(input logic [7:0] c);
        wr(`FCM_UNLOCK1_ADDR, 32'h000000AA);
        wr(`FCM_UNLOCK2_ADDR, 32'h00000055);
        wr(`FCM_UNLOCK1_ADDR, {24'h0, c});
    endtask : unlock

    task automatic erase(input logic [18:0] a, input logic [7:0] c);
        unlock(`FCM_D_ERASE);
        wr(`FCM_UNLOCK1_ADDR, 32'h000000AA);
        wr(a, {24'h0, c});
    endtask : erase

    // Bounded wait so a stuck operation shows as a failed mode check; array writes seen meanwhile are counted
    task automatic wait_idle();
        n_wr = 0;
        for (int n = 0; n < 3000 && busy !== 1'b0; n++)
        begin
            @(posedge i_clock);
            #1;
            if (awr.we === 1'b1)
                n_wr++;
        end
        chk("read mode after run", 32'h1, {31'h0, rmode});
    endtask : wait_idle

    task automatic t_read();
        rd(19'h00104);
        chk("read valid", 32'h1, {31'h0, rvalid});
        chk("read word", {13'h1ABC, 19'h00104}, rdata);
    endtask : t_read

    task automatic t_prog();
        unlock(`FCM_D_PROG);
        wr(19'h00200, 32'h12345678);
        chk("array we", 32'h1, {31'h0, awr.we});
        chk("array addr", {13'h0, 19'h00200}, {13'h0, awr.addr});
        chk("array data", 32'h12345678, awr.data);
        chk("busy", 32'h1, {31'h0, busy});
        rd(19'h00200);
        chk("status only", 32'h0, {4'h0, rdata[31:4]});
        wait_idle();
    endtask : t_prog

    // Reset byte lands where the program word would, at an aligned address, so a missed cancel programs
    task automatic t_cancel_bad();
        unlock(`FCM_D_PROG);
        wr(`FCM_UNLOCK1_ADDR, {24'h0, `FCM_D_RESET});
        chk("cancel no write", 32'h0, {31'h0, awr.we});
        chk("cancel read mode", 32'h1, {31'h0, rmode});
        unlock(`FCM_D_PROG);
        wr(19'h00204, 32'hFFFFFF55);
        chk("program after cancel", 32'h1, {31'h0, awr.we});
        wait_idle();
        unlock(8'h77);
        wr(19'h00208, 32'h00000000);
        chk("invalid no write", 32'h0, {31'h0, awr.we});
        chk("invalid stays read", 32'h1, {31'h0, rmode});
    endtask : t_cancel_bad

    task automatic t_fail();
        logic first;
        fail = 1'b1;
        unlock(`FCM_D_PROG);
        wr(19'h00208, 32'h0);
        repeat (12) @(posedge i_clock);
        #1;
        chk("locked busy", 32'h1, {31'h0, busy});
        chk("fail flag", 32'h1, {31'h0, status[`FCM_STAT_FAIL]});
        fail = 1'b0;
        unlock(`FCM_D_PROG);
        wr(19'h0020C, 32'h0);
        chk("locked refuses program", 32'h0, {31'h0, awr.we});
        rd(19'h00208);
        first = rdata[`FCM_STAT_TOGGLE];
        chk("locked hides array", 32'h0, {4'h0, rdata[31:4]});
        chk("poll shows not done", 32'h0, {31'h0, rdata[`FCM_STAT_POLL]});
        rd(19'h00208);
        chk("toggle flips", {31'h0, ~first}, {31'h0, rdata[`FCM_STAT_TOGGLE]});
        wr(`FCM_UNLOCK1_ADDR, {24'h0, `FCM_D_RESET});
        wait_idle();
    endtask : t_fail

    task automatic t_prot_erase();
        prot = 19'h00001;
        unlock(`FCM_D_PROG);
        wr(19'h00100, 32'h0);
        chk("protected no write", 32'h0, {31'h0, awr.we});
        wait_idle();
        chk("protected no late write", 32'h0, n_wr);
        erase(`FCM_UNLOCK1_ADDR, `FCM_D_CHIP);
        chk("chip erase busy", 32'h1, {31'h0, busy});
        wait_idle();
        chk("chip erase write", 32'h1, n_wr);
        erase(19'h08000, `FCM_D_BLOCK);
        wr(19'h10000, {24'h0, `FCM_D_BLOCK});
        chk("erase timeout open", 32'h1, {31'h0, status[`FCM_STAT_TMO]});
        wait_idle();
        chk("multi erase write", 32'h1, n_wr);
        prot = 19'h7FFFF;
        erase(`FCM_UNLOCK1_ADDR, `FCM_D_CHIP);
        wait_idle();
        chk("all protected no erase", 32'h0, n_wr);
        sec = 1'b1;
        erase(`FCM_UNLOCK1_ADDR, `FCM_D_CHIP);
        chk("secure erase busy", 32'h1, {31'h0, busy});
        wait_idle();
        chk("secure erase write", 32'h1, n_wr);
        sec = 1'b0;
        prot = 19'h0;
    endtask : t_prot_erase

    // The cut program is issued again once commands are taken, as software should do
    task automatic t_reset();
        unlock(`FCM_D_PROG);
        wr(19'h00300, 32'h0);
        @(posedge i_clock);
        #1;
        i_rst = 1'b1;
        @(posedge i_clock);
        #1;
        i_rst = 1'b0;
        chk("reset read mode", 32'h1, {31'h0, rmode});
        chk("reset status", 32'h8, {28'h0, status});
        t_read();
        unlock(`FCM_D_PROG);
        wr(19'h00300, 32'h0);
        chk("restart after reset", 32'h1, {31'h0, awr.we});
        wait_idle();
    endtask : t_reset

    // Main sequence
    initial
    begin
        repeat (3) @(posedge i_clock);
        #1;
        i_rst = 1'b0;
        t_read();
        t_prog();
        t_cancel_bad();
        t_fail();
        t_prot_erase();
        t_reset();
        give_verdict();
    end

    // Watchdog at 20000 cycles, well past the few hundred that the scenarios need
    initial
    begin
        #400000;
        num_errors++;
        give_verdict();
    end
endmodule : fcm_ctrl_tb_top

bind fcm_ctrl fcm_ctrl_monitor fcm_ctrl_monitor_inst (.i_clock(i_clock), .i_rst(i_rst), .i_cpu(i_cpu),
    .i_array_rdata(i_array_rdata), .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_array_wr(o_array_wr),
    .o_busy(o_busy), .o_read_mode(o_read_mode), .o_status(o_status));
`default_nettype wire
